// [include/dcs_consts.vh]
// Constants for the DMA count and collision status block.
// Assumes inclusion by bare name from every design file of the block.
//
// Notes on behaviour
// - Ten-bit read/write count per channel, reset zero
// - Count register bits 15..10 read zero
// - Channel makes count plus one transfers
// - Upper status byte: peripheral collision flags, clear-only
// - Lower status byte: RAM collision flags, clear-only
// - Flag reads one after collision, else zero
`ifndef DCS_CONSTS_VH
`define DCS_CONSTS_VH

// ****************************************************************
// Sizes
// ****************************************************************
`define DCS_NCH          8
`define DCS_CNT_W        10
`define DCS_REG_W        16
`define DCS_ADDR_W       8
`define DCS_CNT_PAD_W    6

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define DCS_RGN_MSB      7
`define DCS_RGN_LSB      5
`define DCS_IDX_MSB      4
`define DCS_IDX_LSB      2
`define DCS_RGN_CNT      3'h0
`define DCS_RGN_MISC     3'h1
`define DCS_RGN_PROG     3'h2
`define DCS_IDX_STAT     3'h0
`define DCS_IDX_IRQ_STAT 3'h1
`define DCS_IDX_IRQ_MASK 3'h2

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define DCS_LANE_LO      0
`define DCS_LANE_HI      1
`define DCS_CNT_HI_MSB   9
`define DCS_CNT_HI_LSB   8
`define DCS_BYTE_LO_MSB  7
`define DCS_BYTE_LO_LSB  0
`define DCS_BYTE_HI_MSB  15
`define DCS_BYTE_HI_LSB  8
`define DCS_CNT_RST      10'h000
`define DCS_CNT_ONE      10'h001
`define DCS_FLAG_RST     8'h00
`define DCS_REG_RST      16'h0000
`define DCS_RESP_OKAY    2'b00
`define DCS_RESP_SLVERR  2'b10

`endif

// [rtl/dcs_chan_counter.v]
// One channel's transfer counter: counts completed transfers of a block.
// Assumes enable and transfer strobe come from DMA logic on clock_i.
`include "dcs_consts.vh"

module dcs_chan_counter (
    input  wire                   clock_i,
    input  wire                   nrst_i,
    input  wire                   en_i,
    input  wire                   xfer_i,
    input  wire [`DCS_CNT_W-1:0]  limit_i,
    output reg                    done_o,
    output reg  [`DCS_CNT_W-1:0]  progress_o
);

    // ****************************************************************
    // Counter
    // ****************************************************************
    // Restart on disable; wrap and pulse done after limit plus one
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            progress_o <= `DCS_CNT_RST;
            done_o     <= 1'b0;
        end else if (!en_i) begin
            progress_o <= `DCS_CNT_RST;
            done_o     <= 1'b0;
        end else if (xfer_i) begin
            if (progress_o == limit_i) begin
                progress_o <= `DCS_CNT_RST;
                done_o     <= 1'b1;
            end else begin
                progress_o <= progress_o + `DCS_CNT_ONE;
                done_o     <= 1'b0;
            end
        end else begin
            done_o <= 1'b0;
        end
    end

endmodule

// [rtl/dcs_flag_bank.v]
// Eight sticky collision flags, one per channel, clear-only for software.
// Assumes set strobes come from logic on clock_i.
`include "dcs_consts.vh"

module dcs_flag_bank (
    input  wire                 clock_i,
    input  wire                 nrst_i,
    input  wire [`DCS_NCH-1:0]  set_i,
    input  wire                 clr_en_i,
    input  wire [`DCS_NCH-1:0]  keep_i,
    output reg  [`DCS_NCH-1:0]  flag_o
);

    reg [`DCS_NCH-1:0] nxt_flag;

    // ****************************************************************
    // Flags
    // ****************************************************************
    // Written zero clears, written one keeps; a set always wins
    always @* begin
        nxt_flag = flag_o;
        if (clr_en_i) begin
            nxt_flag = flag_o & keep_i;
        end
        nxt_flag = nxt_flag | set_i;
    end

    // Flag storage
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flag_o <= `DCS_FLAG_RST;
        end else begin
            flag_o <= nxt_flag;
        end
    end

endmodule

// [rtl/dcs_top.v]
// Count registers, write collision status and interrupt logic of the DMA.
// Assumes an AXI4-Lite master on clock_i and DMA strobes on clock_i.
`include "dcs_consts.vh"

module dcs_top (
    input  wire                            clock_i,
    input  wire                            nrst_i,
    // AXI4-Lite write address
    input  wire                            s_axi_awvalid_i,
    output wire                            s_axi_awready_o,
    input  wire [`DCS_ADDR_W-1:0]          s_axi_awaddr_i,
    // AXI4-Lite write data
    input  wire                            s_axi_wvalid_i,
    output wire                            s_axi_wready_o,
    input  wire [31:0]                     s_axi_wdata_i,
    input  wire [3:0]                      s_axi_wstrb_i,
    // AXI4-Lite write response
    output wire                            s_axi_bvalid_o,
    input  wire                            s_axi_bready_i,
    output wire [1:0]                      s_axi_bresp_o,
    // AXI4-Lite read address
    input  wire                            s_axi_arvalid_i,
    output wire                            s_axi_arready_o,
    input  wire [`DCS_ADDR_W-1:0]          s_axi_araddr_i,
    // AXI4-Lite read data
    output wire                            s_axi_rvalid_o,
    input  wire                            s_axi_rready_i,
    output wire [31:0]                     s_axi_rdata_o,
    output wire [1:0]                      s_axi_rresp_o,
    // DMA channel side
    input  wire [`DCS_NCH-1:0]             chan_en_i,
    input  wire [`DCS_NCH-1:0]             xfer_done_i,
    input  wire [`DCS_NCH-1:0]             periph_coll_i,
    input  wire [`DCS_NCH-1:0]             ram_coll_i,
    output wire [`DCS_NCH*`DCS_CNT_W-1:0]  transfer_count_o,
    output wire [`DCS_NCH-1:0]             block_done_o,
    output wire                            irq_o
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg                     aw_got_ff;
    reg  [`DCS_ADDR_W-1:0]  aw_addr_ff;
    reg                     w_got_ff;
    reg  [31:0]             w_data_ff;
    reg  [3:0]              w_strb_ff;
    reg                     bvalid_ff;
    reg  [1:0]              bresp_ff;
    reg                     rvalid_ff;
    reg  [31:0]             rdata_ff;
    reg  [1:0]              rresp_ff;
    reg  [`DCS_CNT_W-1:0]   cnt_ff [0:`DCS_NCH-1];
    reg  [`DCS_REG_W-1:0]   irq_stat_ff;
    reg  [`DCS_REG_W-1:0]   irq_mask_ff;
    reg                     irq_ff;
    reg  [`DCS_REG_W-1:0]   nxt_irq_stat;
    reg  [`DCS_REG_W-1:0]   rd_word;
    reg                     rd_hit;
    reg                     wr_hit;
    wire                    aw_hs;
    wire                    w_hs;
    wire                    ar_hs;
    wire                    do_wr;
    wire [`DCS_ADDR_W-1:0]  wr_addr;
    wire [31:0]             wr_data;
    wire [3:0]              wr_strb;
    wire [2:0]              wr_rgn;
    wire [2:0]              wr_idx;
    wire [2:0]              rd_rgn;
    wire [2:0]              rd_idx;
    wire                    wr_cnt;
    wire                    wr_stat;
    wire                    wr_mask;
    wire                    rd_irq_clr;
    wire [`DCS_NCH-1:0]     periph_flag;
    wire [`DCS_NCH-1:0]     ram_flag;
    wire [`DCS_NCH-1:0]     done_evt;
    wire [`DCS_CNT_W-1:0]   progress [0:`DCS_NCH-1];
    wire [`DCS_REG_W-1:0]   irq_evt;
    integer                 i;

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    // Address and data taken in either order; blocked while a response waits
    assign s_axi_awready_o = ~aw_got_ff & ~bvalid_ff;
    assign s_axi_wready_o  = ~w_got_ff & ~bvalid_ff;
    assign aw_hs           = s_axi_awvalid_i & s_axi_awready_o;
    assign w_hs            = s_axi_wvalid_i & s_axi_wready_o;
    assign do_wr           = (aw_got_ff | aw_hs) & (w_got_ff | w_hs);

    // Held or live address and data
    assign wr_addr = aw_got_ff ? aw_addr_ff : s_axi_awaddr_i;
    assign wr_data = w_got_ff ? w_data_ff : s_axi_wdata_i;
    assign wr_strb = w_got_ff ? w_strb_ff : s_axi_wstrb_i;
    assign wr_rgn  = wr_addr[`DCS_RGN_MSB:`DCS_RGN_LSB];
    assign wr_idx  = wr_addr[`DCS_IDX_MSB:`DCS_IDX_LSB];

    // Write decode
    assign wr_cnt  = do_wr & (wr_rgn == `DCS_RGN_CNT);
    assign wr_stat = do_wr & (wr_rgn == `DCS_RGN_MISC) & (wr_idx == `DCS_IDX_STAT);
    assign wr_mask = do_wr & (wr_rgn == `DCS_RGN_MISC) & (wr_idx == `DCS_IDX_IRQ_MASK);

    // Mapped write addresses
    always @* begin
        wr_hit = 1'b0;
        case (wr_rgn)
            `DCS_RGN_CNT: begin
                wr_hit = 1'b1;
            end
            `DCS_RGN_PROG: begin
                wr_hit = 1'b1;
            end
            `DCS_RGN_MISC: begin
                wr_hit = (wr_idx == `DCS_IDX_STAT) | (wr_idx == `DCS_IDX_IRQ_STAT) |
                         (wr_idx == `DCS_IDX_IRQ_MASK);
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    // Write handshake state and response
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aw_got_ff  <= 1'b0;
            aw_addr_ff <= {`DCS_ADDR_W{1'b0}};
            w_got_ff   <= 1'b0;
            w_data_ff  <= 32'h0000_0000;
            w_strb_ff  <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `DCS_RESP_OKAY;
        end else begin
            if (do_wr) begin
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_hit ? `DCS_RESP_OKAY : `DCS_RESP_SLVERR;
            end else begin
                if (aw_hs) begin
                    aw_got_ff  <= 1'b1;
                    aw_addr_ff <= s_axi_awaddr_i;
                end
                if (w_hs) begin
                    w_got_ff  <= 1'b1;
                    w_data_ff <= s_axi_wdata_i;
                    w_strb_ff <= s_axi_wstrb_i;
                end
                if (bvalid_ff && s_axi_bready_i) begin
                    bvalid_ff <= 1'b0;
                end
            end
        end
    end

    assign s_axi_bvalid_o = bvalid_ff;
    assign s_axi_bresp_o  = bresp_ff;

    // ****************************************************************
    // Transfer count registers
    // ****************************************************************
    // Byte lanes 0 and 1 write; writes are taken even while enabled
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (i = 0; i < `DCS_NCH; i = i + 1) begin
                cnt_ff[i] <= `DCS_CNT_RST;
            end
        end else if (wr_cnt) begin
            // Behaviour of an active channel is undefined here
            if (wr_strb[`DCS_LANE_LO]) begin
                cnt_ff[wr_idx][`DCS_BYTE_LO_MSB:`DCS_BYTE_LO_LSB] <=
                    wr_data[`DCS_BYTE_LO_MSB:`DCS_BYTE_LO_LSB];
            end
            if (wr_strb[`DCS_LANE_HI]) begin
                cnt_ff[wr_idx][`DCS_CNT_HI_MSB:`DCS_CNT_HI_LSB] <=
                    wr_data[`DCS_CNT_HI_MSB:`DCS_CNT_HI_LSB];
            end
        end
    end

    // ****************************************************************
    // Per-channel transfer counters
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < `DCS_NCH; g = g + 1) begin : g_chan
            dcs_chan_counter u_counter (
                .clock_i    (clock_i),
                .nrst_i     (nrst_i),
                .en_i       (chan_en_i[g]),
                .xfer_i     (xfer_done_i[g]),
                .limit_i    (cnt_ff[g]),
                .done_o     (done_evt[g]),
                .progress_o (progress[g])
            );
            assign transfer_count_o[g*`DCS_CNT_W +: `DCS_CNT_W] = cnt_ff[g];
        end
    endgenerate

    assign block_done_o = done_evt;

    // ****************************************************************
    // Write collision status
    // ****************************************************************
    // Peripheral side flags, upper byte
    dcs_flag_bank u_periph_flags (
        .clock_i  (clock_i),
        .nrst_i   (nrst_i),
        .set_i    (periph_coll_i),
        .clr_en_i (wr_stat & wr_strb[`DCS_LANE_HI]),
        .keep_i   (wr_data[`DCS_BYTE_HI_MSB:`DCS_BYTE_HI_LSB]),
        .flag_o   (periph_flag)
    );

    // DMA RAM side flags, lower byte
    dcs_flag_bank u_ram_flags (
        .clock_i  (clock_i),
        .nrst_i   (nrst_i),
        .set_i    (ram_coll_i),
        .clr_en_i (wr_stat & wr_strb[`DCS_LANE_LO]),
        .keep_i   (wr_data[`DCS_BYTE_LO_MSB:`DCS_BYTE_LO_LSB]),
        .flag_o   (ram_flag)
    );

    // ****************************************************************
    // Interrupt status and mask
    // ****************************************************************
    // Upper byte: collision on either side; lower byte: block done
    assign irq_evt = {periph_coll_i | ram_coll_i, done_evt};

    // Read of the status clears it; a new event wins
    always @* begin
        nxt_irq_stat = irq_stat_ff;
        if (rd_irq_clr) begin
            nxt_irq_stat = `DCS_REG_RST;
        end
        nxt_irq_stat = nxt_irq_stat | irq_evt;
    end

    // Status, mask and registered interrupt level
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_stat_ff <= `DCS_REG_RST;
            irq_mask_ff <= `DCS_REG_RST;
            irq_ff      <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            if (wr_mask && wr_strb[`DCS_LANE_LO]) begin
                irq_mask_ff[`DCS_BYTE_LO_MSB:`DCS_BYTE_LO_LSB] <=
                    wr_data[`DCS_BYTE_LO_MSB:`DCS_BYTE_LO_LSB];
            end
            if (wr_mask && wr_strb[`DCS_LANE_HI]) begin
                irq_mask_ff[`DCS_BYTE_HI_MSB:`DCS_BYTE_HI_LSB] <=
                    wr_data[`DCS_BYTE_HI_MSB:`DCS_BYTE_HI_LSB];
            end
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    assign irq_o = irq_ff;

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    assign s_axi_arready_o = ~rvalid_ff;
    assign ar_hs           = s_axi_arvalid_i & s_axi_arready_o;
    assign rd_rgn          = s_axi_araddr_i[`DCS_RGN_MSB:`DCS_RGN_LSB];
    assign rd_idx          = s_axi_araddr_i[`DCS_IDX_MSB:`DCS_IDX_LSB];
    assign rd_irq_clr      = ar_hs & (rd_rgn == `DCS_RGN_MISC) & (rd_idx == `DCS_IDX_IRQ_STAT);

    // Read data select
    always @* begin
        rd_word = `DCS_REG_RST;
        rd_hit  = 1'b1;
        case (rd_rgn)
            `DCS_RGN_CNT: begin
                rd_word = {{`DCS_CNT_PAD_W{1'b0}}, cnt_ff[rd_idx]};
            end
            `DCS_RGN_PROG: begin
                rd_word = {{`DCS_CNT_PAD_W{1'b0}}, progress[rd_idx]};
            end
            `DCS_RGN_MISC: begin
                case (rd_idx)
                    `DCS_IDX_STAT: begin
                        rd_word = {periph_flag, ram_flag};
                    end
                    `DCS_IDX_IRQ_STAT: begin
                        rd_word = irq_stat_ff;
                    end
                    `DCS_IDX_IRQ_MASK: begin
                        rd_word = irq_mask_ff;
                    end
                    default: begin
                        rd_hit = 1'b0;
                    end
                endcase
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read response register
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= `DCS_RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= {16'h0000, rd_word};
            rresp_ff  <= rd_hit ? `DCS_RESP_OKAY : `DCS_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready_i) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid_o = rvalid_ff;
    assign s_axi_rdata_o  = rdata_ff;
    assign s_axi_rresp_o  = rresp_ff;

endmodule

// [testbench/dcs_dma_model.sv]
// Channel-side model: enables, transfer pulses, collision strobes.
// Assumes bench requests on clock_i; a pace bit high stalls that channel.
module dcs_dma_model (
    input  wire logic       clock_i,
    input  wire logic       nrst_i,
    input  wire logic [7:0] run_i,
    input  wire logic [7:0] pace_i,
    input  wire logic [7:0] pcoll_i,
    input  wire logic [7:0] rcoll_i,
    output logic      [7:0] chan_en_o,
    output logic      [7:0] xfer_done_o,
    output logic      [7:0] periph_coll_o,
    output logic      [7:0] ram_coll_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********
    // Registered drive of the channel side
    // ********
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            chan_en_o     <= 8'h00;
            xfer_done_o   <= 8'h00;
            periph_coll_o <= 8'h00;
            ram_coll_o    <= 8'h00;
        end else begin
            chan_en_o     <= run_i;
            xfer_done_o   <= run_i & ~pace_i; // Transfers only while enabled
            periph_coll_o <= pcoll_i;
            ram_coll_o    <= rcoll_i;
        end
    end
endmodule

// [testbench/dcs_top_monitor.sv]
// Checker for bus handshakes, count readback and block completion.
// Assumes it is bound to dcs_top and sees only its ports.
module dcs_top_monitor (
    input wire logic        clock_i,
    input wire logic        nrst_i,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic [7:0]  s_axi_araddr_i,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [7:0]  chan_en_i,
    input wire logic [7:0]  xfer_done_i,
    input wire logic [79:0] transfer_count_o,
    input wire logic [7:0]  block_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    // ********
    // Bus handshake properties
    // ********
    property p_wr_answer;
        (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o) |=> s_axi_bvalid_o;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write response late");
    property p_wr_stand;
        (s_axi_bvalid_o && !s_axi_bready_i) |=> (s_axi_bvalid_o && $stable(s_axi_bresp_o));
    endproperty
    a_wr_stand: assert property (p_wr_stand) else $error("write response dropped");
    property p_wr_refuse;
        s_axi_bvalid_o |-> (!s_axi_awready_o && !s_axi_wready_o);
    endproperty
    a_wr_refuse: assert property (p_wr_refuse) else $error("write taken during response");
    property p_rd_answer;
        (s_axi_arvalid_i && s_axi_arready_o) |=> s_axi_rvalid_o;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read data late");
    property p_rd_stand;
        (s_axi_rvalid_o && !s_axi_rready_i) |=> (s_axi_rvalid_o && $stable(s_axi_rdata_o));
    endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("read data dropped");

    // ********
    // Count register and block properties
    // ********
    property p_cnt_pad;
        (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i < 8'h20) |=> (s_axi_rdata_o[31:10] == 22'h0);
    endproperty
    a_cnt_pad: assert property (p_cnt_pad) else $error("count upper bits set");
    property p_cnt_reset;
        $rose(nrst_i) |-> (transfer_count_o == 80'h0);
    endproperty
    a_cnt_reset: assert property (p_cnt_reset) else $error("count not zero after reset");
    property p_done_one;
        (chan_en_i[0] && xfer_done_i[0] && transfer_count_o[9:0] == 10'h000) |=> block_done_o[0];
    endproperty
    a_done_one: assert property (p_done_one) else $error("single transfer block not done");
    property p_done_cause;
        block_done_o[0] |-> $past(xfer_done_i[0]);
    endproperty
    a_done_cause: assert property (p_done_cause) else $error("block done without transfer");

    // Main scenarios reached
    c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
    c_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
    c_block: cover property (block_done_o != 8'h00);
endmodule

bind dcs_top dcs_top_monitor u_mon (.*);

// [testbench/test_dma_count_and_collision_status.sv]
// Bench: registers over AXI4-Lite, blocks, collision flags, interrupt.
// Assumes dcs_top and the channel-side model dcs_dma_model.
module test_dma_count_and_collision_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i = 1'b0, nrst_i = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, run = 8'h00, pace = 8'h00, pcoll = 8'h00, rcoll = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0]  wstrb = 4'h0;
    logic [1:0]  bresp, rresp, r;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0]  chan_en, xfer_done, pc_s, rc_s, blk_done, pc, rc, two = 8'h00;
    logic [79:0] cnt_bus;
    logic [9:0]  cnt_v [8];
    int          xfer_n [8], done_n [8];
    int          n_errors = 0, check_count = 0, seed = 32'h36be, n;

    // Clock, 4 ns period
    initial forever #2 clock_i = ~clock_i;

    dcs_top DUT (.clock_i(clock_i), .nrst_i(nrst_i),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .chan_en_i(chan_en), .xfer_done_i(xfer_done), .periph_coll_i(pc_s), .ram_coll_i(rc_s),
        .transfer_count_o(cnt_bus), .block_done_o(blk_done), .irq_o(irq));
    dcs_dma_model u_dma (.clock_i(clock_i), .nrst_i(nrst_i), .run_i(run), .pace_i(pace),
        .pcoll_i(pcoll), .rcoll_i(rcoll), .chan_en_o(chan_en), .xfer_done_o(xfer_done),
        .periph_coll_o(pc_s), .ram_coll_o(rc_s));

    // ********
    // Expectations, comparison and verdict
    // ********
    function automatic logic [31:0] exp_cnt(input logic [9:0] c);
        return {22'h0, c};
    endfunction
    function automatic logic [31:0] exp_stat(input logic [7:0] p, input logic [7:0] x);
        return {16'h0, p, x};
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ********
    // Bus master tasks
    // ********
    task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] s, output logic [1:0] rs);
        int k = 0;
        @(posedge clock_i);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= dv;
        wstrb <= s;
        wvalid <= 1'b1;
        do begin
            @(posedge clock_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            bready <= bvalid;
            k++;
        end while (!(bvalid && bready) && k < 200);
        rs = bresp;
        if (k >= 200) n_errors++;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
        int k = 0;
        @(posedge clock_i);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clock_i);
            if (arready) arvalid <= 1'b0;
            rready <= rvalid;
            k++;
        end while (!(rvalid && rready) && k < 200);
        dv = rdata;
        rs = rresp;
        if (k >= 200) n_errors++;
    endtask

    // Transfers counted per block
    always @(negedge clock_i) begin
        for (int g = 0; g < 8; g++) begin
            if (blk_done[g] === 1'b1) begin
                chk("block xfers", 32'(xfer_n[g]), exp_cnt(cnt_v[g]) + 32'h1);
                xfer_n[g] = 0;
                done_n[g]++;
                if (done_n[g] >= 2) two[g] = 1'b1;
            end
            if (chan_en[g] !== 1'b1) xfer_n[g] = 0;
            else if (xfer_done[g] === 1'b1) xfer_n[g]++;
        end
    end

    // Watchdog
    initial begin
        repeat (40000) @(posedge clock_i);
        n_errors++;
        results();
    end

    // ********
    // Main sequence
    // ********
    initial begin
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            rd(8'(i * 4), d, r);
            chk("reset value", d, 32'h0);
        end
        for (int g = 0; g < 8; g++) begin
            d = $random(seed);
            if (g == 0) d[9:0] = 10'h000;
            if (g == 7) d[9:0] = 10'h3ff;
            cnt_v[g] = d[9:0];
            wr(8'(g * 4), d, 4'hf, r);
            chk("write resp", 32'(r), 32'h0);
            rd(8'(g * 4), d, r);
            chk("cnt rd", d, exp_cnt(cnt_v[g]));
            chk("cnt out", 32'(cnt_bus[g*10 +: 10]), exp_cnt(cnt_v[g]));
        end
        wr(8'h04, 32'hffff_ffa5, 4'h1, r);
        cnt_v[1][7:0] = 8'ha5;
        rd(8'h04, d, r);
        chk("lane write", d, exp_cnt(cnt_v[1]));
        run <= 8'hff;
        n = 0;
        while (two !== 8'hff && n < 20000) begin
            @(posedge clock_i);
            pace <= 8'($random(seed));
            n++;
        end
        run <= 8'h00;
        repeat (4) @(posedge clock_i);
        chk("two blocks", 32'(two), 32'hff);
        rd(8'h40, d, r);
        chk("progress", d, 32'h0);
        rd(8'h24, d, r);
        chk("irq done", d, 32'h00ff);
        rd(8'h24, d, r);
        chk("irq clr read", d, 32'h0);
        pc = 8'($random(seed)) | 8'h01;
        rc = 8'($random(seed)) | 8'h80;
        pcoll <= pc;
        rcoll <= rc;
        @(posedge clock_i);
        pcoll <= 8'h00;
        rcoll <= 8'h00;
        repeat (4) @(posedge clock_i);
        chk("irq masked", 32'(irq), 32'h0);
        wr(8'h28, 32'hff00, 4'hf, r);
        repeat (3) @(posedge clock_i);
        chk("irq raised", 32'(irq), 32'h1);
        rd(8'h20, d, r);
        chk("coll flags", d, exp_stat(pc, rc));
        rd(8'h24, d, r);
        chk("irq status", d, {16'h0, pc | rc, 8'h00});
        repeat (3) @(posedge clock_i);
        chk("irq cleared", 32'(irq), 32'h0);
        wr(8'h20, 32'hffff_ffff, 4'hf, r);
        rd(8'h20, d, r);
        chk("flags kept", d, exp_stat(pc, rc));
        wr(8'h20, 32'h0, 4'h2, r);
        rd(8'h20, d, r);
        chk("upper clr", d, exp_stat(8'h00, rc));
        wr(8'h20, 32'h7f, 4'h1, r);
        rd(8'h20, d, r);
        chk("lower clr", d, exp_stat(8'h00, rc & 8'h7f));
        rd(8'h30, d, r);
        chk("bad rd data", d, 32'h0);
        chk("bad rd resp", 32'(r), 32'h2);
        wr(8'h60, 32'h1, 4'hf, r);
        chk("bad wr resp", 32'(r), 32'h2);
        @(posedge clock_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        rd(8'h1c, d, r);
        chk("cnt reset", d, 32'h0);
        results();
    end
endmodule
